// ===== logic/acq_decoder_pkg.sv
// Shared constants and types for the acquisition instruction decoder.
package acq_decoder_pkg;

    // Register addresses.
    localparam logic [4:0] ADDR_RESULT_LOW = 5'h00;
    localparam logic [4:0] ADDR_RESULT_HIGH = 5'h01;
    localparam logic [4:0] ADDR_OVERLOAD = 5'h02;
    localparam logic [4:0] ADDR_CONV_CTRL = 5'h03;
    localparam logic [4:0] ADDR_GAIN_CHANNEL = 5'h04;
    localparam logic [4:0] ADDR_PIN_STATE = 5'h05;
    localparam logic [4:0] ADDR_PIN_DIR = 5'h06;
    localparam logic [4:0] ADDR_REF_OSC = 5'h07;
    localparam logic [4:0] ADDR_SERIAL_CTRL = 5'h18;
    localparam logic [4:0] ADDR_PART_ID = 5'h1F;

    // Writable bit masks; other bits read as zero, but bit 7 of registers 4 and 5 reads busy.
    localparam logic [7:0] MASK_CONV_CTRL = 8'h2F;
    localparam logic [7:0] MASK_GAIN_CHANNEL = 8'h7F;
    localparam logic [7:0] MASK_PIN_STATE = 8'h0F;
    localparam logic [7:0] MASK_PIN_DIR = 8'h0F;
    localparam logic [7:0] MASK_REF_OSC = 8'h3F;
    localparam logic [7:0] MASK_SERIAL_CTRL = 8'hE7;

    // Field positions.
    localparam int BIT_MODE = 7;
    localparam int BIT_READ = 6;
    localparam int BIT_WIDE = 5;
    localparam int BIT_CONVERT = 7;

    // Reset values and special codes.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RESET_INSTRUCTION = 8'h00;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [3:0] COUNT_BYTE_LAST = 4'h7;
    localparam logic [3:0] COUNT_WORD_LAST = 4'hF;
    localparam logic [1:0] CONV_FALLS_TO_START = 2'h2;

    // Serial port states.
    typedef enum logic [3:0] {
        ST_INSTR = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_READ = 4'b0100,
        ST_SYNC = 4'b1000
    } serial_state_t;

    // Register-mode instruction fields.
    typedef struct packed {
        logic direct;
        logic read;
        logic wide;
        logic [4:0] addr;
    } instr_t;

    // Result delivered by the converter core.
    typedef struct packed {
        logic [13:0] result_bits;
        logic overrange_flag;
        logic [5:0] overload_cause_flags;
    } conv_result_t;

endpackage

// ===== logic/acquisition_instruction_decoder.sv
// Instruction decoder and register file of a serial data acquisition converter.
`timescale 1ns/100ps
module acquisition_instruction_decoder #(
    parameter logic [7:0] PART_ID_VALUE = 8'h5A // Arbitrary identity value.
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic din_in,
    output logic dout_out,
    output logic dout_oe_out,
    input wire logic conversion_clock_in,
    input wire logic conv_done_in,
    input wire acq_decoder_pkg::conv_result_t conv_result_in,
    input wire logic [3:0] digital_pin_bits_in,
    output logic [3:0] digital_pin_bits_out,
    output logic [3:0] pin_direction_bits_out,
    output logic conv_start_out,
    output logic busy_out,
    output logic [2:0] gain_select_field_out,
    output logic [3:0] input_select_field_out,
    output logic [7:0] converter_control_out,
    output logic [7:0] reference_control_out,
    output logic [7:0] serial_control_out
);

    logic [1:0] sclk_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] din_sync_r;
    logic [1:0] cclk_sync_r;
    logic [3:0] pin_sync_a_r;
    logic [3:0] pin_sync_b_r;
    logic sclk_prev_r;
    logic cclk_prev_r;
    logic sclk_rise;
    logic sclk_fall;
    logic cclk_fall;
    logic cs_active;
    logic din_s;

    acq_decoder_pkg::serial_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [6:0] instr_shift_r;
    logic [14:0] wdata_r;
    acq_decoder_pkg::instr_t instr_r;
    logic [7:0] tx_r;
    logic [7:0] instr_final;
    logic [15:0] wdata_final;
    acq_decoder_pkg::instr_t instr_new;
    logic instr_latch;
    logic soft_reset;
    logic direct_cmd;
    logic commit;
    logic [4:0] pair_addr_w;

    logic [7:0] result_low_r;
    logic [7:0] result_high_r;
    logic [7:0] overload_r;
    logic [7:0] conv_ctrl_r;
    logic [6:0] gain_channel_r;
    logic [3:0] pin_state_r;
    logic [3:0] pin_dir_r;
    logic [7:0] ref_osc_r;
    logic [7:0] serial_ctrl_r;

    logic start_req;
    logic [7:0] gain_wval;
    logic [7:0] pin_wval;
    logic start_pend_r;
    logic [1:0] fall_cnt_r;
    logic busy_r;
    logic conv_start_r;

    // Second address of a two-byte transfer: flipping bit 0 adds one to even, subtracts one from odd.
    function automatic logic [4:0] pair_addr(input logic [4:0] a);
        pair_addr = {a[4:1], ~a[0]};
    endfunction

    // Value that a register read returns for a given address.
    function automatic logic [7:0] read_reg(input logic [4:0] a);
        case (a)
            acq_decoder_pkg::ADDR_RESULT_LOW: read_reg = result_low_r;
            acq_decoder_pkg::ADDR_RESULT_HIGH: read_reg = result_high_r;
            acq_decoder_pkg::ADDR_OVERLOAD: read_reg = overload_r;
            acq_decoder_pkg::ADDR_CONV_CTRL: read_reg = conv_ctrl_r;
            acq_decoder_pkg::ADDR_GAIN_CHANNEL: read_reg = {busy_r, gain_channel_r};
            acq_decoder_pkg::ADDR_PIN_STATE: read_reg = {busy_r, 3'h0,
                (pin_dir_r & pin_state_r) | (~pin_dir_r & pin_sync_b_r)};
            acq_decoder_pkg::ADDR_PIN_DIR: read_reg = {4'h0, pin_dir_r};
            acq_decoder_pkg::ADDR_REF_OSC: read_reg = ref_osc_r;
            acq_decoder_pkg::ADDR_SERIAL_CTRL: read_reg = serial_ctrl_r;
            acq_decoder_pkg::ADDR_PART_ID: read_reg = PART_ID_VALUE;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // True when a committed write covers the target address.
    function automatic logic wr_hit(input logic [4:0] target);
        wr_hit = commit && (instr_r.addr == target || (instr_r.wide && pair_addr_w == target));
    endfunction

    // Byte that a committed write delivers to the target address.
    function automatic logic [7:0] wr_val(input logic [4:0] target);
        if (instr_r.addr == target) begin
            wr_val = instr_r.wide ? wdata_final[15:8] : wdata_final[7:0];
        end else begin
            wr_val = wdata_final[7:0];
        end
    endfunction

    // Two-flop synchronisers for all pins, then one more stage for edge finding.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_sync_r <= 2'h0;
            cs_sync_r <= 2'h3;
            din_sync_r <= 2'h0;
            cclk_sync_r <= 2'h0;
            pin_sync_a_r <= 4'h0;
            pin_sync_b_r <= 4'h0;
            sclk_prev_r <= 1'b0;
            cclk_prev_r <= 1'b0;
        end else begin
            sclk_sync_r <= {sclk_sync_r[0], sclk_in};
            cs_sync_r <= {cs_sync_r[0], cs_n_in};
            din_sync_r <= {din_sync_r[0], din_in};
            cclk_sync_r <= {cclk_sync_r[0], conversion_clock_in};
            pin_sync_a_r <= digital_pin_bits_in;
            pin_sync_b_r <= pin_sync_a_r;
            sclk_prev_r <= sclk_sync_r[1];
            cclk_prev_r <= cclk_sync_r[1];
        end
    end

    // Edge events and instruction decode.
    always_comb begin
        cs_active = ~cs_sync_r[1];
        din_s = din_sync_r[1];
        sclk_rise = cs_active & sclk_sync_r[1] & ~sclk_prev_r;
        sclk_fall = cs_active & ~sclk_sync_r[1] & sclk_prev_r;
        cclk_fall = ~cclk_sync_r[1] & cclk_prev_r;
        instr_final = {instr_shift_r, din_s};
        instr_new = acq_decoder_pkg::instr_t'(instr_final);
        wdata_final = {wdata_r, din_s};
        pair_addr_w = pair_addr(instr_r.addr);
        instr_latch = sclk_rise && state_r == acq_decoder_pkg::ST_INSTR
            && bit_cnt_r == acq_decoder_pkg::COUNT_BYTE_LAST;
        direct_cmd = instr_latch && instr_final[acq_decoder_pkg::BIT_MODE];
        soft_reset = instr_latch && instr_final == acq_decoder_pkg::RESET_INSTRUCTION;
        commit = sclk_rise && state_r == acq_decoder_pkg::ST_WRITE
            && bit_cnt_r == (instr_r.wide ? acq_decoder_pkg::COUNT_WORD_LAST : acq_decoder_pkg::COUNT_BYTE_LAST);
    end

    // Serial port sequencer: instruction byte, then data bytes in or out.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= acq_decoder_pkg::ST_INSTR;
            bit_cnt_r <= acq_decoder_pkg::COUNT_ZERO;
            instr_shift_r <= 7'h00;
            wdata_r <= 15'h0000;
            instr_r <= '0;
            tx_r <= 8'h00;
            dout_out <= 1'b0;
            dout_oe_out <= 1'b0;
        end else if (!cs_active) begin
            state_r <= acq_decoder_pkg::ST_INSTR;
            bit_cnt_r <= acq_decoder_pkg::COUNT_ZERO;
            dout_oe_out <= 1'b0;
        end else begin
            dout_oe_out <= 1'b1;
            case (state_r)
                acq_decoder_pkg::ST_INSTR: begin
                    if (sclk_rise) begin
                        instr_shift_r <= instr_final[6:0];
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (instr_latch) begin
                            bit_cnt_r <= acq_decoder_pkg::COUNT_ZERO;
                            instr_r <= instr_new;
                            if (soft_reset) begin
                                state_r <= acq_decoder_pkg::ST_SYNC;
                            end else if (instr_new.direct) begin
                                state_r <= acq_decoder_pkg::ST_INSTR;
                            end else if (instr_new.read) begin
                                state_r <= acq_decoder_pkg::ST_READ;
                                tx_r <= read_reg(instr_new.addr);
                            end else begin
                                state_r <= acq_decoder_pkg::ST_WRITE;
                            end
                        end
                    end
                end
                acq_decoder_pkg::ST_WRITE: begin
                    if (sclk_rise) begin
                        wdata_r <= wdata_final[14:0];
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (commit) begin
                            bit_cnt_r <= acq_decoder_pkg::COUNT_ZERO;
                            state_r <= acq_decoder_pkg::ST_INSTR;
                        end
                    end
                end
                acq_decoder_pkg::ST_READ: begin
                    // Data changes on falling edges so the host samples it stable on rising edges.
                    if (sclk_fall) begin
                        dout_out <= tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                    end else if (sclk_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == acq_decoder_pkg::COUNT_BYTE_LAST && instr_r.wide) begin
                            tx_r <= read_reg(pair_addr_w);
                        end
                        if (bit_cnt_r == (instr_r.wide ? acq_decoder_pkg::COUNT_WORD_LAST
                                : acq_decoder_pkg::COUNT_BYTE_LAST)) begin
                            bit_cnt_r <= acq_decoder_pkg::COUNT_ZERO;
                            state_r <= acq_decoder_pkg::ST_INSTR;
                        end
                    end
                end
                acq_decoder_pkg::ST_SYNC: begin
                    // After a soft reset with select held low, the first one bit re-frames the port.
                    if (sclk_rise && din_s) begin
                        state_r <= acq_decoder_pkg::ST_INSTR;
                        bit_cnt_r <= acq_decoder_pkg::COUNT_ZERO;
                    end
                end
                default: begin
                    state_r <= acq_decoder_pkg::ST_INSTR;
                    bit_cnt_r <= acq_decoder_pkg::COUNT_ZERO;
                end
            endcase
        end
    end

    // Register file; all registers clear on a soft reset.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_low_r <= acq_decoder_pkg::REG_RESET;
            result_high_r <= acq_decoder_pkg::REG_RESET;
            overload_r <= acq_decoder_pkg::REG_RESET;
            conv_ctrl_r <= acq_decoder_pkg::REG_RESET;
            gain_channel_r <= 7'h00;
            pin_state_r <= 4'h0;
            pin_dir_r <= 4'h0;
            ref_osc_r <= acq_decoder_pkg::REG_RESET;
            serial_ctrl_r <= acq_decoder_pkg::REG_RESET;
        end else if (soft_reset) begin
            result_low_r <= acq_decoder_pkg::REG_RESET;
            result_high_r <= acq_decoder_pkg::REG_RESET;
            overload_r <= acq_decoder_pkg::REG_RESET;
            conv_ctrl_r <= acq_decoder_pkg::REG_RESET;
            gain_channel_r <= 7'h00;
            pin_state_r <= 4'h0;
            pin_dir_r <= 4'h0;
            ref_osc_r <= acq_decoder_pkg::REG_RESET;
            serial_ctrl_r <= acq_decoder_pkg::REG_RESET;
        end else begin
            if (conv_done_in) begin
                result_low_r <= {conv_result_in.result_bits[5:0], 1'b0, conv_result_in.overrange_flag};
                result_high_r <= conv_result_in.result_bits[13:6];
                overload_r <= {2'h0, conv_result_in.overload_cause_flags};
            end
            if (direct_cmd) begin
                gain_channel_r <= instr_final[6:0];
            end else if (wr_hit(acq_decoder_pkg::ADDR_GAIN_CHANNEL)) begin
                gain_channel_r <= gain_wval[6:0];
            end
            if (wr_hit(acq_decoder_pkg::ADDR_CONV_CTRL)) begin
                conv_ctrl_r <= wr_val(acq_decoder_pkg::ADDR_CONV_CTRL) & acq_decoder_pkg::MASK_CONV_CTRL;
            end
            if (wr_hit(acq_decoder_pkg::ADDR_PIN_STATE)) begin
                pin_state_r <= pin_wval[3:0];
            end
            if (wr_hit(acq_decoder_pkg::ADDR_PIN_DIR)) begin
                pin_dir_r <= 4'(wr_val(acq_decoder_pkg::ADDR_PIN_DIR));
            end
            if (wr_hit(acq_decoder_pkg::ADDR_REF_OSC)) begin
                ref_osc_r <= wr_val(acq_decoder_pkg::ADDR_REF_OSC) & acq_decoder_pkg::MASK_REF_OSC;
            end
            if (wr_hit(acq_decoder_pkg::ADDR_SERIAL_CTRL)) begin
                serial_ctrl_r <= wr_val(acq_decoder_pkg::ADDR_SERIAL_CTRL) & acq_decoder_pkg::MASK_SERIAL_CTRL;
            end
        end
    end

    // Start requests from a direct command or a write setting the convert bit of register 4 or 5.
    always_comb begin
        gain_wval = wr_val(acq_decoder_pkg::ADDR_GAIN_CHANNEL);
        pin_wval = wr_val(acq_decoder_pkg::ADDR_PIN_STATE);
        start_req = direct_cmd
            || (wr_hit(acq_decoder_pkg::ADDR_GAIN_CHANNEL) && gain_wval[acq_decoder_pkg::BIT_CONVERT])
            || (wr_hit(acq_decoder_pkg::ADDR_PIN_STATE) && pin_wval[acq_decoder_pkg::BIT_CONVERT]);
    end

    // Conversion launch on the second conversion clock fall; busy until the core reports done.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_pend_r <= 1'b0;
            fall_cnt_r <= 2'h0;
            busy_r <= 1'b0;
            conv_start_r <= 1'b0;
        end else if (soft_reset) begin
            start_pend_r <= 1'b0;
            fall_cnt_r <= 2'h0;
            busy_r <= 1'b0;
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= 1'b0;
            if (start_req && !busy_r && !start_pend_r) begin
                start_pend_r <= 1'b1;
                fall_cnt_r <= 2'h0;
            end else if (start_pend_r && cclk_fall) begin
                fall_cnt_r <= fall_cnt_r + 2'h1;
                if (fall_cnt_r + 2'h1 == acq_decoder_pkg::CONV_FALLS_TO_START) begin
                    start_pend_r <= 1'b0;
                    conv_start_r <= 1'b1;
                end
            end
            // When a start request and a completion share a cycle with busy low, the set path is listed last so it wins.
            if (conv_done_in) begin
                busy_r <= 1'b0;
            end
            if (start_req && !busy_r) begin
                busy_r <= 1'b1;
            end
        end
    end

    // Register-driven outputs.
    always_comb begin
        conv_start_out = conv_start_r;
        busy_out = busy_r;
        gain_select_field_out = gain_channel_r[6:4];
        input_select_field_out = gain_channel_r[3:0];
        converter_control_out = conv_ctrl_r;
        reference_control_out = ref_osc_r;
        serial_control_out = serial_ctrl_r;
        digital_pin_bits_out = pin_state_r;
        pin_direction_bits_out = pin_dir_r;
    end

endmodule

// ===== verif/acquisition_instruction_decoder_props.sv
// Concurrent checks on the top-level ports of the instruction decoder.
`timescale 1ns/100ps
module acquisition_instruction_decoder_props (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic conversion_clock_in,
    input wire logic conv_done_in,
    input wire logic dout_oe_out,
    input wire logic conv_start_out,
    input wire logic busy_out,
    input wire logic [2:0] gain_select_field_out,
    input wire logic [3:0] input_select_field_out,
    input wire logic [3:0] pin_direction_bits_out,
    input wire logic [7:0] converter_control_out
);
    logic conv_clk_r;
    logic [1:0] fall_cnt_r;
    // Counts raw conversion clock falls while a start is pending; the synchroniser may hide one.
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_clk_r <= 1'b0;
            fall_cnt_r <= 2'h0;
        end else begin
            conv_clk_r <= conversion_clock_in;
            if (!busy_out || conv_start_out) begin
                fall_cnt_r <= 2'h0;
            end else if (conv_clk_r && !conversion_clock_in && fall_cnt_r != 2'h3) begin
                fall_cnt_r <= fall_cnt_r + 2'h1;
            end
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_start_one_cycle: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse longer than one cycle");
    a_start_after_busy: assert property (conv_start_out |-> busy_out && $past(busy_out, 2))
        else $error("start without a pending request");
    a_start_two_falls: assert property (conv_start_out |-> fall_cnt_r inside {2'h1, 2'h2})
        else $error("start not on second conversion clock fall");
    a_done_clears_busy: assert property (busy_out && conv_done_in |=> !busy_out)
        else $error("busy stays high after conversion done");
    a_busy_fall_cause: assert property ($fell(busy_out) |-> $past(conv_done_in) ||
        (gain_select_field_out == 3'h0 && input_select_field_out == 4'h0 && pin_direction_bits_out == 4'h0))
        else $error("busy dropped without done or reset");
    a_idle_regs_stable: assert property (cs_n_in [*5] |-> $stable(gain_select_field_out) &&
        $stable(pin_direction_bits_out) && $stable(converter_control_out))
        else $error("register changed while deselected");
    a_busy_needs_frame: assert property (cs_n_in [*5] |-> !$rose(busy_out))
        else $error("busy rose without a serial command");
    a_oe_idle: assert property (cs_n_in [*4] |-> !dout_oe_out)
        else $error("data output enabled while deselected");
    a_oe_select: assert property (!cs_n_in [*4] |-> dout_oe_out)
        else $error("data output not enabled while selected");
endmodule

// ===== verif/host_serial_model.sv
// Behavioural host that frames instruction and data bits on the serial port.
`timescale 1ns/100ps
module host_serial_model (
    input wire logic clk_in,
    input wire logic dout_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic din_out
);
    // Idle bus: deselected, serial clock standing low.
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out = 1'b0;
    end
    // Sends nbits MSB first, four core cycles low and four high per bit, sampling data late in the high phase.
    task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge clk_in);
        cs_n_out <= 1'b0;
        repeat (3) @(negedge clk_in);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk_out <= 1'b0;
            din_out <= tx[i];
            repeat (4) @(negedge clk_in);
            sclk_out <= 1'b1;
            repeat (4) @(negedge clk_in);
            rx = {rx[22:0], dout_in};
        end
        sclk_out <= 1'b0;
        din_out <= ~din_out; // Released line no longer shows the last bit.
        repeat (6) @(negedge clk_in);
        cs_n_out <= 1'b1;
        repeat (6) @(negedge clk_in);
    endtask
endmodule

// ===== verif/acquisition_instruction_decoder_tb.sv
// Self-checking bench for the acquisition instruction decoder.
`timescale 1ns/100ps
module acquisition_instruction_decoder_tb;
    localparam logic [7:0] ID_VAL = 8'hC3; // Arbitrary identity value.
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic conv_clk = 1'b0;
    logic done = 1'b0;
    logic [3:0] pins = 4'h0;
    acq_decoder_pkg::conv_result_t res = '0;
    logic sclk, cs_n, din, dout, oe, start, busy;
    logic [2:0] gain, gs;
    logic [3:0] chan, pout, pdir, ch;
    logic [7:0] cc, rc, sc, hi, lo;
    logic [15:0] q;
    logic [23:0] sync_rx;
    int error_cnt = 0;
    int num_checks = 0;
    int starts = 0;
    int n;
    logic [4:0] raddr [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h18, 5'h1F, 5'h08, 5'h1E};
    logic [4:0] waddr [4] = '{5'h03, 5'h06, 5'h07, 5'h18};
    logic [4:0] ro [4] = '{5'h01, 5'h02, 5'h1F, 5'h08};
    logic [7:0] wmask [4] = '{acq_decoder_pkg::MASK_CONV_CTRL, acq_decoder_pkg::MASK_PIN_DIR,
        acq_decoder_pkg::MASK_REF_OSC, acq_decoder_pkg::MASK_SERIAL_CTRL};
    acquisition_instruction_decoder #(.PART_ID_VALUE(ID_VAL)) uut (
        .core_clk_in(clk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
        .dout_out(dout), .dout_oe_out(oe), .conversion_clock_in(conv_clk), .conv_done_in(done),
        .conv_result_in(res), .digital_pin_bits_in(pins), .digital_pin_bits_out(pout),
        .pin_direction_bits_out(pdir), .conv_start_out(start), .busy_out(busy),
        .gain_select_field_out(gain), .input_select_field_out(chan), .converter_control_out(cc),
        .reference_control_out(rc), .serial_control_out(sc));
    host_serial_model host (.clk_in(clk), .dout_in(dout), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));
    // Core clock, free-running conversion clock and a count of start pulses.
    initial forever #10 clk = ~clk;
    initial forever #180 conv_clk = ~conv_clk;
    always @(posedge clk) if (start === 1'b1) starts++;
    initial begin
        #2000000;
        error_cnt++;
        finish_test();
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One instruction plus data; an 8-bit write byte sits in d[15:8], read bytes come back in q.
    task automatic acc(input logic [7:0] ins, input logic [15:0] d);
        logic [23:0] rx;
        int nb;
        nb = ins[7] ? 8 : (ins[5] ? 24 : 16);
        host.xfer({ins, d} >> (24 - nb), nb, rx);
        q = rx[15:0];
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
        acc({3'b010, a}, 16'h0000);
        check(what, exp, q[7:0]);
    endtask
    task automatic pulse_done;
        @(negedge clk);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (raddr[i]) rd(raddr[i], raddr[i] == 5'h1F ? ID_VAL : 8'h00, "reset read");
        $display("Test reset values done");
        for (int i = 0; i < 4; i++) begin
            acc({3'b000, waddr[i]}, 16'hFF00);
            rd(waddr[i], wmask[i], "masked register");
        end
        check("control out", acq_decoder_pkg::MASK_CONV_CTRL, cc);
        check("direction out", acq_decoder_pkg::MASK_PIN_DIR, {4'h0, pdir});
        check("serial out", acq_decoder_pkg::MASK_SERIAL_CTRL, sc);
        acc(8'h26, 16'h051A);
        acc(8'h67, 16'h0000);
        check("odd first byte", 8'h1A, q[15:8]);
        check("odd second byte", 8'h05, q[7:0]);
        check("reference out", 8'h1A, rc);
        $display("Test register writes done");
        foreach (ro[i]) acc({3'b000, ro[i]}, 16'hFF00);
        acc(8'h20, 16'hFFFF);
        rd(5'h06, 8'h05, "direction kept");
        rd(5'h07, 8'h1A, "reference kept");
        rd(5'h1F, ID_VAL, "identity kept");
        rd(5'h01, 8'h00, "result kept");
        $display("Test refused writes done");
        for (int g = 0; g < 8; g++) begin
            gs = 3'(g);
            ch = ~{gs, gs[0]};
            n = starts;
            acc({1'b1, gs, ch}, 16'h0000);
            check("gain field", {5'h00, gs}, {5'h00, gain});
            check("input field", {4'h0, ch}, {4'h0, chan});
            rd(5'h04, {1'b1, gs, ch}, "busy gain channel");
            check("start count", 8'(n + 1), 8'(starts));
            res = {gs, 11'h4B5 ^ 11'(g * 37), gs[0], gs, 3'h5};
            pulse_done();
            hi = res.result_bits[13:6];
            lo = {res.result_bits[5:0], 1'b0, res.overrange_flag};
            acc(g[0] ? 8'h61 : 8'h60, 16'h0000);
            check("first result byte", g[0] ? hi : lo, q[15:8]);
            check("second result byte", g[0] ? lo : hi, q[7:0]);
            rd(5'h02, {2'b00, res.overload_cause_flags}, "overload flags");
            rd(5'h04, {1'b0, gs, ch}, "idle gain channel");
        end
        $display("Test direct mode done");
        pins = 4'h6;
        n = starts;
        acc(8'h24, 16'hB78A);
        check("gain written", 8'h03, {5'h00, gain});
        check("pins written", 8'h0A, {4'h0, pout});
        acc(8'h65, 16'h0000);
        check("pin state", {4'h8, (4'hA & 4'h5) | (pins & ~4'h5)}, q[15:8]);
        check("gain busy", 8'hB7, q[7:0]);
        check("start count", 8'(n + 1), 8'(starts));
        pulse_done();
        $display("Test register start done");
        acc(8'hFF, 16'h0000);
        acc(8'h00, 16'h0000);
        check("busy cleared", 8'h00, {7'h00, busy});
        check("gain cleared", 8'h00, {5'h00, gain});
        rd(5'h06, 8'h00, "direction cleared");
        rd(5'h04, 8'h00, "gain channel cleared");
        $display("Test soft reset done");
        // Select stays low after the reset byte; zeros are ignored until a one re-frames the port.
        host.xfer(24'h00019A, 19, sync_rx);
        check("resync gain", 8'h01, {5'h00, gain});
        check("resync input", 8'h0A, {4'h0, chan});
        $display("Test resync done");
        finish_test();
    end
endmodule
bind acquisition_instruction_decoder acquisition_instruction_decoder_props chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .conversion_clock_in(conversion_clock_in),
    .conv_done_in(conv_done_in), .dout_oe_out(dout_oe_out), .conv_start_out(conv_start_out), .busy_out(busy_out),
    .gain_select_field_out(gain_select_field_out), .input_select_field_out(input_select_field_out),
    .pin_direction_bits_out(pin_direction_bits_out), .converter_control_out(converter_control_out));
